// [core/exec_pkg.sv]
// Purpose: Shared constants and types for the three-instruction execute block
// Assumes: 25 MHz hclk, single clock domain
// Notes: Quarter phases advance on a divided enable pulse
package exec_pkg;
    // Clock and quarter-phase timing
    localparam int CLK_MHZ = 25;
    localparam int QTR_NS = 80;
    localparam int QTR_CYC = (QTR_NS * CLK_MHZ + 999) / 1000;
    localparam int QDIV_W = 4;
    localparam logic [QDIV_W-1:0] QDIV_LAST = QDIV_W'(QTR_CYC - 1);
    // Widths
    localparam int PC_W = 21;
    localparam int DADDR_W = 12;
    localparam int BSR_W = 6;
    localparam int BANK_W = DADDR_W - 8;
    // Opcode fields
    localparam logic [5:0] OPC_AND = 6'h05;
    localparam logic [7:0] OPC_BRC = 8'hE2;
    localparam logic [3:0] OPC_BCLR = 4'h9;
    localparam int DEST_BIT = 9;
    localparam int ACC_BIT = 8;
    localparam int BIDX_LSB = 9;
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [BANK_W-1:0] ACC_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACC_HI_BANK = 4'hF;
    // Register map
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] BANK_ADDR = 8'h04;
    localparam logic [7:0] STAT_ADDR = 8'h08;
    localparam logic [7:0] TAKEN_ADDR = 8'h0C;
    localparam int CTRL_EXT = 0;
    localparam int CTRL_RUN = 1;
    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam logic [BSR_W-1:0] BSR_RST = 6'h00;
    localparam int CNT_W = 16;

    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
    typedef enum logic [1:0] {OP_NONE, OP_AND, OP_BRC, OP_BCLR} op_t;
    typedef enum logic [1:0] {AM_ACCESS, AM_BANKED, AM_INDEXED} amode_t;
endpackage

// [core/carry_branch_bit_clear_exec.sv]
// Purpose: Executes and_working_with_file tail, branch_on_carry_set and clear_register_bit
// Assumes: instr_in, carry_in, w_in, fsr2_in, pc_in, dmem_rdata come from hclk logic
// Notes: Status flag generation is outside this block
// Function
// - AND with file: decode Q1, read Q2, compute Q3, write destination Q4.
// - Carry branch jumps only when carry is one, else falls through.
// - Taken target is incremented counter plus twice signed eight-bit displacement.
// - Carry branch is one word, one cycle untaken, two cycles taken.
// - Taken first cycle decodes, reads literal, computes, loads counter in Q4.
// - Taken second cycle does nothing in all four phases, flushing prefetch.
// - Untaken branch decodes, reads, computes but never loads the counter.
// - Bit clear zeroes one selected bit, keeps other bits and flags.
// - Access bit zero resolves the address inside the access bank.
// - Access bit one joins low four bits of bank select register with eight-bit address.
// - Access bit zero with extended set uses indexed offset for f up to 95.
`timescale 1ns/1ps
`default_nettype none
module carry_branch_bit_clear_exec
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Core inputs
    input wire logic [15:0] instr_in,
    input wire logic carry_in,
    input wire logic [7:0] w_in,
    input wire logic [DADDR_W-1:0] fsr2_in,
    input wire logic [PC_W-1:0] pc_in,
    // Data memory
    output logic [DADDR_W-1:0] dmem_addr,
    output logic dmem_rd,
    input wire logic [7:0] dmem_rdata,
    output logic dmem_we,
    output logic [7:0] dmem_wdata,
    // Working register and program counter
    output logic w_we,
    output logic [7:0] w_wdata,
    output logic pc_load,
    output logic [PC_W-1:0] pc_target,
    // Phase indication
    output logic [1:0] quarter_phase,
    output logic quarter_tick,
    output logic flush_cycle
);
    // Divider state
    logic [QDIV_W-1:0] qdiv_r, qdiv_nxt;
    logic qtick;
    // Execute state
    phase_t phase_r, phase_nxt;
    op_t op_r, op_nxt;
    amode_t amode_r, amode_nxt;
    logic [15:0] ir_r, ir_nxt;
    logic [7:0] opnd_r, opnd_nxt;
    logic taken_r, taken_nxt, flush_r, flush_nxt;
    logic [DADDR_W-1:0] addr_r, addr_nxt, fsr2_r, fsr2_nxt;
    logic rd_r, rd_nxt, dwe_r, dwe_nxt, wwe_r, wwe_nxt, pcl_r, pcl_nxt;
    logic [7:0] dwd_r, dwd_nxt, wwd_r, wwd_nxt;
    logic [PC_W-1:0] tgt_r, tgt_nxt, base_r, base_nxt;
    // Register file
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [BSR_W-1:0] bsr_r, bsr_nxt;
    logic [CNT_W-1:0] tcnt_r, tcnt_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic wpend_r, wpend_nxt;
    logic [7:0] waddr_r, waddr_nxt;

    // Decode helpers
    op_t dec_op;
    amode_t dec_am;
    logic [7:0] dec_f;
    logic [DADDR_W-1:0] dec_addr;
    logic [7:0] bmask;
    logic [PC_W-1:0] disp2;

    assign qtick = ctrl_r[CTRL_RUN] && (qdiv_r == QDIV_LAST);
    assign dec_f = instr_in[7:0];
    assign bmask = 8'h01 << ir_r[BIDX_LSB +: 3];
    assign disp2 = {{(PC_W-9){ir_r[7]}}, ir_r[7:0], 1'b0};

    always_comb begin
        dec_op = OP_NONE;
        if (instr_in[15:8] == OPC_BRC) begin
            dec_op = OP_BRC;
        end else if (instr_in[15:10] == OPC_AND) begin
            dec_op = OP_AND;
        end else if (instr_in[15:12] == OPC_BCLR) begin
            dec_op = OP_BCLR;
        end
        if (instr_in[ACC_BIT]) begin
            dec_am = AM_BANKED;
            dec_addr = {bsr_r[BANK_W-1:0], dec_f};
        end else if (ctrl_r[CTRL_EXT] && dec_f <= IDX_LIMIT) begin
            dec_am = AM_INDEXED;
            dec_addr = DADDR_W'(fsr2_in + {{(DADDR_W-8){1'b0}}, dec_f});
        end else begin
            dec_am = AM_ACCESS;
            dec_addr = {(dec_f <= IDX_LIMIT) ? ACC_LO_BANK : ACC_HI_BANK, dec_f};
        end
    end

    always_comb begin
        qdiv_nxt = qdiv_r;
        if (ctrl_r[CTRL_RUN]) begin
            qdiv_nxt = qtick ? '0 : QDIV_W'(qdiv_r + 1'b1);
        end
    end

    always_comb begin
        phase_nxt = phase_r;
        op_nxt = op_r;
        amode_nxt = amode_r;
        ir_nxt = ir_r;
        opnd_nxt = opnd_r;
        taken_nxt = taken_r;
        flush_nxt = flush_r;
        addr_nxt = addr_r;
        fsr2_nxt = fsr2_r;
        rd_nxt = rd_r;
        dwd_nxt = dwd_r;
        wwd_nxt = wwd_r;
        tgt_nxt = tgt_r;
        base_nxt = base_r;
        tcnt_nxt = tcnt_r;
        // Write strobes are one-cycle pulses at Q4 entry
        dwe_nxt = 1'b0;
        wwe_nxt = 1'b0;
        pcl_nxt = 1'b0;
        if (qtick) begin
            case (phase_r)
                PH_Q1: begin
                    phase_nxt = PH_Q2;
                    op_nxt = flush_r ? OP_NONE : dec_op;
                    ir_nxt = instr_in;
                    amode_nxt = dec_am;
                    fsr2_nxt = fsr2_in;
                    addr_nxt = dec_addr;
                    rd_nxt = !flush_r && (dec_op == OP_AND || dec_op == OP_BCLR);
                end
                PH_Q2: begin
                    phase_nxt = PH_Q3;
                    if (rd_r) begin
                        opnd_nxt = dmem_rdata;
                    end
                    rd_nxt = 1'b0;
                end
                PH_Q3: begin
                    phase_nxt = PH_Q4;
                    case (op_r)
                        OP_AND: begin
                            dwe_nxt = ir_r[DEST_BIT];
                            wwe_nxt = !ir_r[DEST_BIT];
                            dwd_nxt = w_in & opnd_r;
                            wwd_nxt = w_in & opnd_r;
                        end
                        OP_BCLR: begin
                            dwe_nxt = 1'b1;
                            dwd_nxt = opnd_r & ~bmask;
                        end
                        OP_BRC: begin
                            base_nxt = pc_in;
                            tgt_nxt = PC_W'(pc_in + disp2);
                            pcl_nxt = carry_in;
                            taken_nxt = carry_in;
                            if (carry_in) begin
                                tcnt_nxt = CNT_W'(tcnt_r + 1'b1);
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                PH_Q4: begin
                    phase_nxt = PH_Q1;
                    flush_nxt = taken_r;
                    taken_nxt = 1'b0;
                    op_nxt = OP_NONE;
                end
                default: phase_nxt = PH_Q1;
            endcase
        end
    end

    // Bus slave: zero wait state, writes land in the data phase
    logic addr_ok;
    assign addr_ok = hsel && htrans[1] && hready;

    always_comb begin
        ctrl_nxt = ctrl_r;
        bsr_nxt = bsr_r;
        rdat_nxt = rdat_r;
        wpend_nxt = addr_ok && hwrite;
        waddr_nxt = addr_ok ? haddr[7:0] : waddr_r;
        if (wpend_r) begin
            case (waddr_r)
                CTRL_ADDR: ctrl_nxt = hwdata[1:0];
                BANK_ADDR: bsr_nxt = hwdata[BSR_W-1:0];
                default: begin
                end
            endcase
        end
        if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                CTRL_ADDR: rdat_nxt = {30'h0, ctrl_r};
                BANK_ADDR: rdat_nxt = {26'h0, bsr_r};
                STAT_ADDR: rdat_nxt = {27'h0, taken_r, flush_r, 1'b0, op_r};
                TAKEN_ADDR: rdat_nxt = {16'h0, tcnt_r};
                default: rdat_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            qdiv_r <= '0;
            phase_r <= PH_Q1;
            op_r <= OP_NONE;
            amode_r <= AM_ACCESS;
            ir_r <= 16'h0000;
            opnd_r <= 8'h00;
            taken_r <= 1'b0;
            flush_r <= 1'b0;
            addr_r <= '0;
            fsr2_r <= '0;
            rd_r <= 1'b0;
            dwe_r <= 1'b0;
            wwe_r <= 1'b0;
            pcl_r <= 1'b0;
            dwd_r <= 8'h00;
            wwd_r <= 8'h00;
            tgt_r <= '0;
            base_r <= '0;
            tcnt_r <= '0;
            ctrl_r <= CTRL_RST;
            bsr_r <= BSR_RST;
            rdat_r <= 32'h0;
            wpend_r <= 1'b0;
            waddr_r <= 8'h00;
        end else begin
            qdiv_r <= qdiv_nxt;
            phase_r <= phase_nxt;
            op_r <= op_nxt;
            amode_r <= amode_nxt;
            ir_r <= ir_nxt;
            opnd_r <= opnd_nxt;
            taken_r <= taken_nxt;
            flush_r <= flush_nxt;
            addr_r <= addr_nxt;
            fsr2_r <= fsr2_nxt;
            rd_r <= rd_nxt;
            dwe_r <= dwe_nxt;
            wwe_r <= wwe_nxt;
            pcl_r <= pcl_nxt;
            dwd_r <= dwd_nxt;
            wwd_r <= wwd_nxt;
            tgt_r <= tgt_nxt;
            base_r <= base_nxt;
            tcnt_r <= tcnt_nxt;
            ctrl_r <= ctrl_nxt;
            bsr_r <= bsr_nxt;
            rdat_r <= rdat_nxt;
            wpend_r <= wpend_nxt;
            waddr_r <= waddr_nxt;
        end
    end

    assign hrdata = rdat_r;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign dmem_addr = addr_r;
    assign dmem_rd = rd_r;
    assign dmem_we = dwe_r;
    assign dmem_wdata = dwd_r;
    assign w_we = wwe_r;
    assign w_wdata = wwd_r;
    assign pc_load = pcl_r;
    assign pc_target = tgt_r;
    assign quarter_phase = phase_r;
    assign quarter_tick = qtick;
    assign flush_cycle = flush_r;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    and_dest_q4_a: assert property ((dwe_r || wwe_r) |-> phase_r == PH_Q4 && op_r != OP_BRC)
        else $error("file or W written outside Q4");
    brc_carry_a: assert property (pcl_r |-> op_r == OP_BRC && taken_r && phase_r == PH_Q4)
        else $error("counter loaded without taken branch");
    brc_target_a: assert property (pcl_r |-> tgt_r == PC_W'(base_r + 2 * PC_W'(signed'(ir_r[7:0]))))
        else $error("branch target not base plus twice displacement");
    brc_flush_a: assert property (qtick && phase_r == PH_Q4 && taken_r |=> flush_r && phase_r == PH_Q1)
        else $error("taken branch did not add a flush cycle");
    flush_idle_a: assert property (flush_r |-> !dwe_r && !wwe_r && !pcl_r && !rd_r && op_r == OP_NONE)
        else $error("activity during flush cycle");
    brc_untaken_a: assert property (qtick && phase_r == PH_Q3 && op_r == OP_BRC && !carry_in
        |=> !pcl_r ##1 !pcl_r)
        else $error("untaken branch loaded counter");
    bclr_bit_a: assert property (dwe_r && op_r == OP_BCLR |-> dwd_r == (opnd_r & ~bmask))
        else $error("bit clear result wrong");
    acc_bank_a: assert property (rd_r && amode_r == AM_ACCESS
        |-> addr_r[DADDR_W-1:8] == ((addr_r[7:0] <= IDX_LIMIT) ? ACC_LO_BANK : ACC_HI_BANK))
        else $error("access bank address wrong");
    bank_sel_a: assert property (rd_r && amode_r == AM_BANKED |-> ir_r[ACC_BIT] && addr_r[7:0] == ir_r[7:0])
        else $error("banked address wrong");
    idx_offset_a: assert property (rd_r && amode_r == AM_INDEXED
        |-> addr_r == DADDR_W'(fsr2_r + {4'h0, ir_r[7:0]}) && ir_r[7:0] <= IDX_LIMIT)
        else $error("indexed address wrong");
    brc_decode_a: assert property (phase_r == PH_Q2 && op_r == OP_BRC |-> ir_r[15:8] == OPC_BRC)
        else $error("branch decoded from wrong opcode");
    bclr_decode_a: assert property (phase_r == PH_Q2 && op_r == OP_BCLR |-> ir_r[15:12] == OPC_BCLR)
        else $error("bit clear decoded from wrong opcode");

    taken_c: cover property (pcl_r ##[1:20] flush_r);
    untaken_c: cover property (qtick && phase_r == PH_Q3 && op_r == OP_BRC && !carry_in);
    bclr_c: cover property (dwe_r && op_r == OP_BCLR);
    and_w_c: cover property (wwe_r);
endmodule
`default_nettype wire

// [dv/carry_branch_bit_clear_exec_tb.sv]
// Purpose: Self-checking bench for the three-instruction execute block
// Assumes: zero-wait AHB slave, quarter of two hclk cycles
// Notes: Instructions are launched at the edge that ends quarter_phase_four
`timescale 1ns/1ps
`default_nettype none
module carry_branch_bit_clear_exec_tb;
    import exec_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    wire logic hready;
    logic [31:0] hrdata, rdv;
    logic hreadyout, hresp;
    logic [15:0] instr_in = 16'h0;
    logic carry_in = 1'b0;
    logic [7:0] w_in = 8'h0;
    logic [7:0] dmem_rdata = 8'h0;
    logic [DADDR_W-1:0] fsr2_in = 12'h100;
    logic [PC_W-1:0] pc_in = 21'h001000;
    logic [DADDR_W-1:0] dmem_addr, wa;
    logic dmem_rd, dmem_we, w_we, pc_load, quarter_tick, flush_cycle;
    logic [7:0] dmem_wdata, w_wdata, wd, wwd;
    logic [PC_W-1:0] pc_target, tgt;
    logic [1:0] quarter_phase;
    int fails = 0;
    int compares = 0;
    int n_ld, n_we, n_wwe, n_rd, n_fl;

    assign hready = hreadyout;

    carry_branch_bit_clear_exec uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .instr_in(instr_in),
        .carry_in(carry_in), .w_in(w_in), .fsr2_in(fsr2_in), .pc_in(pc_in), .dmem_addr(dmem_addr),
        .dmem_rd(dmem_rd), .dmem_rdata(dmem_rdata), .dmem_we(dmem_we), .dmem_wdata(dmem_wdata),
        .w_we(w_we), .w_wdata(w_wdata), .pc_load(pc_load), .pc_target(pc_target),
        .quarter_phase(quarter_phase), .quarter_tick(quarter_tick), .flush_cycle(flush_cycle));

    initial begin
        forever #20 hclk = ~hclk;
    end

    task automatic print_verdict;
        $display("fails=%0d compares=%0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wait_ready;
        for (int i = 0; i < 16; i++) begin
            @(posedge hclk);
            if (hready === 1'b1) return;
        end
        chk(32'h0, 32'h1);
        print_verdict();
    endtask

    // Entered right after a rising edge; leaves at the edge that ends the data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    // Runs one instruction cycle and tallies the pulses seen in it
    task automatic exec(input logic cont, input logic [15:0] ins, input logic c, input logic [7:0] w,
                        input logic [7:0] rd);
        int i;
        if (!cont) begin
            // Park a no-op so the cycle skipped while waiting does not rerun the last instruction
            @(posedge hclk);
            instr_in <= 16'h0000;
            for (i = 0; i < 24; i++) begin
                @(negedge hclk);
                if (quarter_phase === 2'h3 && quarter_tick === 1'b1) break;
            end
            if (i == 24) begin
                chk(32'h0, 32'h1);
                print_verdict();
            end
        end
        @(posedge hclk);
        instr_in <= ins;
        carry_in <= c;
        w_in <= w;
        dmem_rdata <= rd;
        n_ld = 0; n_we = 0; n_wwe = 0; n_rd = 0; n_fl = 0;
        for (i = 0; i < 8; i++) begin
            @(negedge hclk);
            if (pc_load === 1'b1) begin n_ld++; tgt = pc_target; end
            if (dmem_we === 1'b1) begin n_we++; wd = dmem_wdata; wa = dmem_addr; end
            if (w_we === 1'b1) begin n_wwe++; wwd = w_wdata; end
            if (dmem_rd === 1'b1) n_rd++;
            if (flush_cycle === 1'b1) n_fl++;
        end
    endtask

    task automatic t_regs;
        ahb(1'b0, CTRL_ADDR, 32'h0, rdv); chk(rdv, 32'h2);
        chk(hresp, 32'h0);
        chk(hreadyout, 32'h1);
        ahb(1'b0, BANK_ADDR, 32'h0, rdv); chk(rdv, 32'h0);
        ahb(1'b1, BANK_ADDR, 32'hFFFF_FF2A, rdv);
        ahb(1'b0, BANK_ADDR, 32'h0, rdv); chk(rdv, 32'h2A);
        ahb(1'b1, 8'h14, 32'h5A5A_5A5A, rdv);
        ahb(1'b0, 8'h14, 32'h0, rdv); chk(rdv, 32'h0);
    endtask

    task automatic t_and;
        // result to working register, then to file, in quarter_phase_four
        exec(1'b0, 16'h1440, 1'b0, 8'h17, 8'hC2);
        chk(n_wwe, 1); chk(wwd, 8'h02); chk(n_we, 0); chk(n_rd, 2);
        exec(1'b1, 16'h1640, 1'b0, 8'h17, 8'hC2);
        chk(n_we, 1); chk(wd, 8'h02); chk(wa, 12'h040); chk(n_wwe, 0);
    endtask

    task automatic t_branch;
        // extreme displacements, each with a flushed follower
        exec(1'b0, 16'hE280, 1'b1, 8'h0, 8'h0);
        chk(n_ld, 1); chk(tgt, 21'h000F00); chk(n_we, 0); chk(n_fl, 0);
        exec(1'b1, 16'h9F33, 1'b1, 8'h0, 8'hFF);
        chk(n_fl, 8); chk(n_we, 0); chk(n_ld, 0); chk(n_rd, 0);
        exec(1'b1, 16'hE27F, 1'b1, 8'h0, 8'h0);
        chk(n_ld, 1); chk(tgt, 21'h0010FE);
        exec(1'b1, 16'hE201, 1'b1, 8'h0, 8'h0);
        chk(n_fl, 8); chk(n_ld, 0);
        exec(1'b0, 16'hE205, 1'b0, 8'h0, 8'h0);
        chk(n_ld, 0); chk(n_fl, 0);
        exec(1'b1, 16'h9F33, 1'b0, 8'h0, 8'hFF);
        chk(n_fl, 0); chk(n_we, 1);
        exec(1'b0, 16'hE380, 1'b1, 8'h0, 8'h0);
        chk(n_ld, 0); chk(n_fl, 0);
        @(posedge hclk);
        ahb(1'b0, TAKEN_ADDR, 32'h0, rdv); chk(rdv, 32'h2);
    endtask

    task automatic bclr(input logic [15:0] ins, input logic [7:0] rd, input logic [7:0] ewd,
                        input logic [DADDR_W-1:0] ewa);
        exec(1'b0, ins, 1'b0, 8'h0, rd);
        chk(n_we, 1); chk(wd, ewd); chk(wa, ewa); chk(n_wwe, 0); chk(n_ld, 0);
    endtask

    task automatic t_bclr;
        bclr(16'h9F33, 8'hC7, 8'h47, 12'hA33);
        bclr(16'h9080, 8'hFF, 8'hFE, 12'hF80);
        bclr(16'h9620, 8'h0F, 8'h07, 12'h020);
        @(posedge hclk);
        ahb(1'b1, CTRL_ADDR, 32'h3, rdv);
        bclr(16'h9620, 8'h0F, 8'h07, 12'h120);
        bclr(16'h9E5F, 8'hFF, 8'h7F, 12'h15F);
        bclr(16'h9A60, 8'h20, 8'h00, 12'hF60);
    endtask

    // Stop the quarter divider inside the flush cycle after a taken branch
    task automatic t_halt;
        int n_tk;
        n_tk = 0;
        exec(1'b0, 16'hE201, 1'b1, 8'h0, 8'h0);
        chk(n_ld, 1);
        chk(tgt, 21'h001002);
        @(posedge hclk);
        ahb(1'b1, CTRL_ADDR, 32'h0, rdv);
        for (int i = 0; i < 8; i++) begin
            @(negedge hclk);
            if (quarter_tick !== 1'b0) n_tk++;
            if (flush_cycle !== 1'b1) n_tk++;
        end
        chk(n_tk, 0);
        ahb(1'b0, STAT_ADDR, 32'h0, rdv);
        chk(rdv, 32'h8);
        ahb(1'b0, CTRL_ADDR, 32'h0, rdv);
        chk(rdv, 32'h0);
    endtask

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_and();
        t_branch();
        t_bclr();
        t_halt();
        print_verdict();
    end
endmodule
`default_nettype wire
